// >>> verilog/dcf_map.svh
/*
  constants for the dual-clock fifo port control: widths, depth, config count.
  assumes inclusion by bare name from the package and dcf_port_ctrl; dcf_edge does not include it.
*/
`ifndef DCF_MAP_SVH
`define DCF_MAP_SVH
`define DCF_DATA_W     36
`define DCF_CFG_W      8
`define DCF_DEPTH      16
`define DCF_PTR_W      4
`define DCF_CFG_N      4
`define DCF_CFG_IDX_W  2
`define DCF_CFG_RESET  8'h00
`endif

// >>> verilog/dcf_pkg.sv
/*
  types shared by the fifo port control modules.
  assumes dcf_map.svh is on the include path.
*/
`include "dcf_map.svh"
package dcf_pkg;
  typedef logic [`DCF_DATA_W-1:0]  dcf_word_type;
  typedef logic [`DCF_PTR_W:0]     dcf_ptr_type;
  typedef logic [`DCF_CFG_W-1:0]   dcf_cfg_type;
endpackage

// >>> verilog/dcf_edge.sv
/*
  two-flop synchroniser with rising-edge detect of an outside clock or level.
  assumes one system clock; the first flop feeds only the second.
*/
`timescale 1ns/1ps
module dcf_edge (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic async_in,
  output logic      level_q,
  output logic      rise
);
  logic meta_q;
  logic sync_q;
  logic meta_d;
  logic sync_d;
  logic level_d;

  always_comb begin
    meta_d  = async_in;
    sync_d  = meta_q;
    level_d = sync_q;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_q  <= 1'b0;
      sync_q  <= 1'b0;
      level_q <= 1'b0;
    end else begin
      meta_q  <= meta_d;
      sync_q  <= sync_d;
      level_q <= level_d;
    end
  end

  assign rise = sync_q & ~level_q;
endmodule

// >>> verilog/dcf_port_ctrl.sv
/*
  dual-clock fifo port control: write port on wclk, read port on rclk, both
  sampled by the 200 MHz system clock. fifo storage, config registers, flags.
  assumes host pins are asynchronous; levels and data pass three flops, clock edges two, before use.
*/
`timescale 1ns/1ps
`include "dcf_map.svh"
module dcf_port_ctrl (
  input  wire logic                   clock,
  input  wire logic                   nrst,
  input  wire logic                   wclk,
  input  wire logic                   rclk,
  input  wire logic                   write_en_n,
  input  wire logic                   read_en_n,
  input  wire logic                   input_mask_n,
  input  wire logic                   out_drive_n,
  input  wire logic                   load_select_n,
  input  wire logic [`DCF_DATA_W-1:0] data_in,
  output logic      [`DCF_DATA_W-1:0] data_out,
  output logic      [`DCF_DATA_W-1:0] data_out_oe,
  output logic                        empty_flag_n,
  output logic                        full_flag_n
);
  logic rst_n;
  logic rst_meta_q;
  logic rst_sync_q;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end
  assign rst_n = rst_sync_q;

  // clocks and controls: synchronised; data is sampled with the same delay
  logic wclk_rise;
  logic rclk_rise;
  logic wen_n_s;
  logic ren_n_s;
  logic mask_n_s;
  logic oe_n_s;
  logic ld_s;
  dcf_edge u_wclk (.clock(clock), .rst_n(rst_n), .async_in(wclk),
                   .level_q(), .rise(wclk_rise));
  dcf_edge u_rclk (.clock(clock), .rst_n(rst_n), .async_in(rclk),
                   .level_q(), .rise(rclk_rise));
  dcf_edge u_wen  (.clock(clock), .rst_n(rst_n), .async_in(write_en_n),
                   .level_q(wen_n_s), .rise());
  dcf_edge u_ren  (.clock(clock), .rst_n(rst_n), .async_in(read_en_n),
                   .level_q(ren_n_s), .rise());
  dcf_edge u_mask (.clock(clock), .rst_n(rst_n), .async_in(input_mask_n),
                   .level_q(mask_n_s), .rise());
  dcf_edge u_oe   (.clock(clock), .rst_n(rst_n), .async_in(out_drive_n),
                   .level_q(oe_n_s), .rise());
  dcf_edge u_ld   (.clock(clock), .rst_n(rst_n), .async_in(load_select_n),
                   .level_q(ld_s), .rise());

  // data bus: three flops so it lines up with the synchronised write enable and mask levels
  dcf_pkg::dcf_word_type din_m_q;
  dcf_pkg::dcf_word_type din_m_d;
  dcf_pkg::dcf_word_type din_s_q;
  dcf_pkg::dcf_word_type din_s_d;
  dcf_pkg::dcf_word_type din_q;
  dcf_pkg::dcf_word_type din_d;

  always_comb begin
    din_m_d = data_in;
    din_s_d = din_m_q;
    din_d   = din_s_q;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      din_m_q <= 36'h0_0000_0000;
      din_s_q <= 36'h0_0000_0000;
      din_q   <= 36'h0_0000_0000;
    end else begin
      din_m_q <= din_m_d;
      din_s_q <= din_s_d;
      din_q   <= din_d;
    end
  end

  // storage and pointers
  dcf_pkg::dcf_word_type mem_q [`DCF_DEPTH];
  dcf_pkg::dcf_word_type mem_d [`DCF_DEPTH];
  dcf_pkg::dcf_cfg_type  cfg_q [`DCF_CFG_N];
  dcf_pkg::dcf_cfg_type  cfg_d [`DCF_CFG_N];
  dcf_pkg::dcf_ptr_type  wptr_q;
  dcf_pkg::dcf_ptr_type  wptr_d;
  dcf_pkg::dcf_ptr_type  rptr_q;
  dcf_pkg::dcf_ptr_type  rptr_d;
  logic [`DCF_CFG_IDX_W-1:0] cwidx_q;
  logic [`DCF_CFG_IDX_W-1:0] cwidx_d;
  logic [`DCF_CFG_IDX_W-1:0] cridx_q;
  logic [`DCF_CFG_IDX_W-1:0] cridx_d;
  dcf_pkg::dcf_word_type dout_q;
  dcf_pkg::dcf_word_type dout_d;
  logic [`DCF_DATA_W-1:0] oe_q;
  logic [`DCF_DATA_W-1:0] oe_d;
  logic empty_n_q;
  logic empty_n_d;
  logic full_n_q;
  logic full_n_d;

  logic is_full;
  logic is_empty;
  logic wr_ev;
  logic rd_ev;
  assign is_full  = (wptr_q[`DCF_PTR_W] != rptr_q[`DCF_PTR_W]) &&
                    (wptr_q[`DCF_PTR_W-1:0] == rptr_q[`DCF_PTR_W-1:0]);
  assign is_empty = (wptr_q == rptr_q);
  assign wr_ev = wclk_rise && !wen_n_s;
  assign rd_ev = rclk_rise && !ren_n_s;

  // write side: fifo or config, chosen by load select
  always_comb begin
    mem_d   = mem_q;
    cfg_d   = cfg_q;
    wptr_d  = wptr_q;
    cwidx_d = cwidx_q;
    if (wr_ev) begin
      if (ld_s) begin
        if (!is_full) begin
          if (!mask_n_s) begin
            mem_d[wptr_q[`DCF_PTR_W-1:0]] = din_q;
          end
          wptr_d = wptr_q + 5'h01;
        end
      end else begin
        cfg_d[cwidx_q] = din_q[`DCF_CFG_W-1:0];
        cwidx_d        = cwidx_q + 2'h1;
      end
    end
  end

  // read side: a read of an empty fifo leaves pointer and output alone
  always_comb begin
    rptr_d  = rptr_q;
    cridx_d = cridx_q;
    dout_d  = dout_q;
    if (rd_ev) begin
      if (ld_s) begin
        if (!is_empty) begin
          dout_d = mem_q[rptr_q[`DCF_PTR_W-1:0]];
          rptr_d = rptr_q + 5'h01;
        end
      end else begin
        dout_d  = {28'h000_0000, cfg_q[cridx_q]};
        cridx_d = cridx_q + 2'h1;
      end
    end
  end

  // flags follow their own clock's edges and show the state after that edge,
  // so the host never sees room that the edge it just used has taken
  always_comb begin
    empty_n_d = empty_n_q;
    full_n_d  = full_n_q;
    oe_d      = {`DCF_DATA_W{~oe_n_s}};
    if (rclk_rise) begin
      empty_n_d = (wptr_d != rptr_d);
    end
    if (wclk_rise) begin
      full_n_d = (wptr_d[`DCF_PTR_W] == rptr_d[`DCF_PTR_W]) ||
                 (wptr_d[`DCF_PTR_W-1:0] != rptr_d[`DCF_PTR_W-1:0]);
    end
  end

  // write side state
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < `DCF_DEPTH; i++) begin
        mem_q[i] <= 36'h0_0000_0000;
      end
      for (int i = 0; i < `DCF_CFG_N; i++) begin
        cfg_q[i] <= `DCF_CFG_RESET;
      end
      wptr_q  <= 5'h00;
      cwidx_q <= 2'h0;
    end else begin
      mem_q   <= mem_d;
      cfg_q   <= cfg_d;
      wptr_q  <= wptr_d;
      cwidx_q <= cwidx_d;
    end
  end

  // read side state
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rptr_q  <= 5'h00;
      cridx_q <= 2'h0;
      dout_q  <= 36'h0_0000_0000;
    end else begin
      rptr_q  <= rptr_d;
      cridx_q <= cridx_d;
      dout_q  <= dout_d;
    end
  end

  // flag state kept active low, drive state active high, so the pins come straight off flops
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      oe_q      <= 36'h0_0000_0000;
      empty_n_q <= 1'b0;
      full_n_q  <= 1'b1;
    end else begin
      oe_q      <= oe_d;
      empty_n_q <= empty_n_d;
      full_n_q  <= full_n_d;
    end
  end

  assign data_out     = dout_q;
  assign data_out_oe  = oe_q;
  assign empty_flag_n = empty_n_q;
  assign full_flag_n  = full_n_q;
endmodule

// >>> testbench/dcf_host.sv
/* host clocks: 24 ns pulses, low between. needs controls set by the bench. */
`timescale 1ns/1ps
module dcf_host (
  output logic wclk = 1'b0,
  output logic rclk = 1'b0
);
  task automatic pulse(logic rd);
    #23;
    if (rd) rclk = 1'b1;
    else wclk = 1'b1;
    #24;
    {wclk, rclk} = 2'h0;
  endtask
endmodule

// >>> testbench/dcf_port_ctrl_asserts.sv
/* checks on dcf_port_ctrl pins. needs one clock and low nrst. */
`timescale 1ns/1ps
module dcf_port_ctrl_asserts (
  input wire logic        clock,
  input wire logic        nrst,
  input wire logic        wclk,
  input wire logic        rclk,
  input wire logic        read_en_n,
  input wire logic        out_drive_n,
  input wire logic        load_select_n,
  input wire logic [35:0] data_out,
  input wire logic [35:0] data_out_oe,
  input wire logic        empty_flag_n,
  input wire logic        full_flag_n
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  oe_off_a: assert property (out_drive_n [*8] |-> data_out_oe == '0) else $error("oe");
  oe_on_a: assert property ((!out_drive_n) [*8] |-> &data_out_oe) else $error("oe");
  rd_idle_a: assert property ((!rclk) [*8] |-> $stable(data_out)) else $error("q");
  rd_off_a: assert property (read_en_n [*8] |-> $stable(data_out)) else $error("q");
  empty_sync_a: assert property ((!rclk) [*8] |-> $stable(empty_flag_n))
    else $error("ef");
  full_sync_a: assert property ((!wclk) [*8] |-> $stable(full_flag_n))
    else $error("ff");
  cfg_zero_a: assert property ((!load_select_n) [*8] ##0 $changed(data_out) |->
    data_out[35:8] == '0) else $error("cfg");
  reset_val_a: assert property ($rose(nrst) |-> !data_out_oe && !empty_flag_n
    && full_flag_n) else $error("rst");
endmodule
bind dcf_port_ctrl dcf_port_ctrl_asserts u_chk (
  .clock         (clock),
  .nrst          (nrst),
  .wclk          (wclk),
  .rclk          (rclk),
  .read_en_n     (read_en_n),
  .out_drive_n   (out_drive_n),
  .load_select_n (load_select_n),
  .data_out      (data_out),
  .data_out_oe   (data_out_oe),
  .empty_flag_n  (empty_flag_n),
  .full_flag_n   (full_flag_n)
);

// >>> testbench/tb_dual_clock_fifo_port_control.sv
/* bench for dcf_port_ctrl. needs dcf_host. */
`timescale 1ns/1ps
module tb_dual_clock_fifo_port_control;
  logic        clock = 1'b0;
  logic        nrst, wclk, rclk, write_en_n, read_en_n, input_mask_n, m;
  logic        out_drive_n, load_select_n, empty_flag_n, full_flag_n;
  logic [35:0] data_in, data_out, data_out_oe, w, mem [16];
  logic [31:0] lfsr = 32'h3035_2b08;
  int          failures, n_tests, cyc, i;
  dcf_port_ctrl DUT (
    .clock         (clock),
    .nrst          (nrst),
    .wclk          (wclk),
    .rclk          (rclk),
    .write_en_n    (write_en_n),
    .read_en_n     (read_en_n),
    .input_mask_n  (input_mask_n),
    .out_drive_n   (out_drive_n),
    .load_select_n (load_select_n),
    .data_in       (data_in),
    .data_out      (data_out),
    .data_out_oe   (data_out_oe),
    .empty_flag_n  (empty_flag_n),
    .full_flag_n   (full_flag_n)
  );
  dcf_host host (
    .wclk (wclk),
    .rclk (rclk)
  );
  function automatic logic [35:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return {lfsr[7:4], lfsr};
  endfunction
  task automatic check(logic [35:0] seen, logic [35:0] exp);
    n_tests++;
    if (seen !== exp) $display("[FAIL] %0t %h %h", $time, seen, exp);
    failures += int'(seen !== exp);
  endtask
  task automatic xfer(logic rd, logic en_n, logic ls_n, logic [35:0] d);
    @(posedge clock);
    #1;
    if (rd) read_en_n = en_n;
    else {write_en_n, input_mask_n, data_in} = {en_n, m, d};
    load_select_n = ls_n;
    host.pulse(rd);
    #8;
  endtask
  task automatic close_out(int extra);
    failures += extra;
    $display("%0d checks, %0d failures", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial forever #2.5 clock = ~clock;
  always @(posedge clock) if (++cyc == 3000) close_out(1);
  initial begin
    {nrst, m, out_drive_n, data_in} = '0;
    {write_en_n, read_en_n, load_select_n} = 3'h7;
    repeat (2) @(posedge clock);
    #1 nrst = 1'b1;
    repeat (10) @(posedge clock);
    check(data_out_oe, 36'hF_FFFF_FFFF);
    for (i = 0; i < 8; i++) begin
      if (i < 4) mem[i] = rnd();
      xfer(i > 3, 1'b0, 1'b0, mem[i % 4]);
      if (i > 3) check(data_out, {28'h0, mem[i - 4][7:0]});
    end
    $display("cfg end");
    for (int r = 0; r < 2; r++) begin
      for (i = 0; i < 17; i++) begin
        w = rnd();
        m = r == 1 && (i == 0 || w[35]);
        if (!m && i < 16) mem[i] = w;
        xfer(1'b0, 1'b0, 1'b1, w);
        check(36'(full_flag_n), 36'(i < 15));
        if (i == 7) xfer(1'b0, 1'b1, 1'b1, rnd());
      end
      check(36'(full_flag_n), '0);
      for (i = 0; i < 17; i++) begin
        xfer(1'b1, 1'b0, 1'b1, w);
        check(data_out, mem[i < 16 ? i : 15]);
        check(36'(empty_flag_n), 36'(i < 15));
        if (i == 7) xfer(1'b1, 1'b1, 1'b1, w);
      end
      check(36'(empty_flag_n), '0);
      $display("fifo round end");
    end
    @(posedge clock);
    #1 out_drive_n = 1'b1;
    repeat (10) @(posedge clock);
    check(data_out_oe, '0);
    $display("drive end");
    @(posedge clock);
    #1 nrst = 1'b0;
    repeat (2) @(posedge clock);
    #1 nrst = 1'b1;
    check(data_out, '0);
    check(36'({empty_flag_n, full_flag_n}), 36'h0_0000_0001);
    $display("reset end");
    close_out(0);
  end
endmodule
